// File: irq_mask_pkg.sv
// Purpose: shared constants for the upper interrupt enable byte block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   printed offsets are not multiples of four, so byte address is four times index
package irq_mask_pkg;
	localparam int          SRC_COUNT        = 8;
	localparam logic [7:0]  MASK_HI_INDEX    = 8'h45;
	localparam logic [11:0] MASK_HI_ADDR     = {2'h0, MASK_HI_INDEX, 2'h0};
	localparam logic [11:0] STATUS_ADDR      = 12'h400;
	localparam logic [11:0] RAW_ADDR         = 12'h404;
	localparam logic [7:0]  MASK_HI_RESET    = 8'h00;
	localparam logic [7:0]  STATUS_RESET     = 8'h00;
	localparam int          BIT_EXT_FRAME    = 7;
	localparam int          BIT_SEC_CHANGE   = 6;
	localparam int          BIT_PHASE_ALARM  = 5;
	localparam int          BIT_SEC_LOST     = 4;
	localparam int          BIT_B_CODE_ERR   = 3;
	localparam int          BIT_B_SIG_LOSS   = 2;
	localparam int          BIT_A_CODE_ERR   = 1;
	localparam int          BIT_A_SIG_LOSS   = 0;
endpackage

// File: irq_bus_if.sv
// Purpose: carries decoded register writes from the bus slave to the register store
// Assumes: single clock
// Notes:   write strobe is one cycle per completed apb write
interface irq_bus_if;
	logic        wr_mask;
	logic        wr_status;
	logic [7:0]  wdata;
	logic [7:0]  mask;
	logic [7:0]  status;
	modport slave (output wr_mask, output wr_status, output wdata, input mask, input status);
	modport store (input wr_mask, input wr_status, input wdata, output mask, output status);
endinterface

// File: irq_apb_slave.sv
// Purpose: apb slave decode for the interrupt enable block
// Assumes: zero wait states, pslverr on unmapped address
// Notes:   read data registered in the setup cycle
module irq_apb_slave
	import irq_mask_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [7:0]  raw_in,
	output logic      [31:0] prdata_out,
	output logic             pslverr_out,
	irq_bus_if.slave         bus
);
	logic mapped;
	logic access;

	always_comb begin
		if (paddr_in == MASK_HI_ADDR) begin
			mapped = 1'b1;
		end else if (paddr_in == STATUS_ADDR) begin
			mapped = 1'b1;
		end else if (paddr_in == RAW_ADDR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	assign access        = psel_in && penable_in;
	assign pslverr_out   = access && !mapped;
	assign bus.wdata     = pwdata_in[7:0];
	assign bus.wr_mask   = access && pwrite_in && (paddr_in == MASK_HI_ADDR);
	assign bus.wr_status = access && pwrite_in && (paddr_in == STATUS_ADDR);

	// setup-cycle capture keeps read data a flop output with no wait state
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			if (paddr_in == MASK_HI_ADDR) begin
				prdata_out <= {24'h00_0000, bus.mask};
			end else if (paddr_in == STATUS_ADDR) begin
				prdata_out <= {24'h00_0000, bus.status};
			end else if (paddr_in == RAW_ADDR) begin
				prdata_out <= {24'h00_0000, raw_in};
			end else begin
				prdata_out <= 32'h0000_0000;
			end
		end
	end
endmodule

// File: irq_mask_store.sv
// Purpose: enable byte and sticky status storage
// Assumes: event inputs are one-cycle or level, synchronous
// Notes:   set wins over write-one-to-clear
module irq_mask_store
	import irq_mask_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] event_in,
	irq_bus_if.store        bus
);
	logic [7:0] mask;
	logic [7:0] status;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask <= MASK_HI_RESET;
		end else if (bus.wr_mask) begin
			mask <= bus.wdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < SRC_COUNT; g++) begin : g_stat
			always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					status[g] <= STATUS_RESET[g];
				end else if (event_in[g]) begin
					status[g] <= 1'b1;
				end else if (bus.wr_status && bus.wdata[g]) begin
					status[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign bus.mask   = mask;
	assign bus.status = status;
endmodule

// File: interrupt_mask_upper_byte.sv
// Purpose: upper enable byte of the interrupt mask, with sticky alarm status and irq output
// Assumes: alarm inputs synchronous to clk_sys_in, apb register access
// Notes:   irq is a level, high while any enabled status bit is set
module interrupt_mask_upper_byte
	import irq_mask_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        ext_frame_pulse_alarm_in,
	input  wire logic        secondary_path_state_change_in,
	input  wire logic        phase_monitor_alarm_in,
	input  wire logic        secondary_path_sources_lost_in,
	input  wire logic        coded_input_b_code_error_in,
	input  wire logic        coded_input_b_signal_loss_in,
	input  wire logic        coded_input_a_code_error_in,
	input  wire logic        coded_input_a_signal_loss_in,
	output logic      [7:0]  gated_alarm_out,
	output logic             irq_out
);
	irq_bus_if  bus ();
	logic [7:0] events;
	logic [7:0] next_gated;

	assign events[BIT_EXT_FRAME]   = ext_frame_pulse_alarm_in;
	assign events[BIT_SEC_CHANGE]  = secondary_path_state_change_in;
	assign events[BIT_PHASE_ALARM] = phase_monitor_alarm_in;
	assign events[BIT_SEC_LOST]    = secondary_path_sources_lost_in;
	assign events[BIT_B_CODE_ERR]  = coded_input_b_code_error_in;
	assign events[BIT_B_SIG_LOSS]  = coded_input_b_signal_loss_in;
	assign events[BIT_A_CODE_ERR]  = coded_input_a_code_error_in;
	assign events[BIT_A_SIG_LOSS]  = coded_input_a_signal_loss_in;

	assign pready_out = 1'b1;

	irq_apb_slave u_slave (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.pwrite_in   (pwrite_in),
		.paddr_in    (paddr_in),
		.pwdata_in   (pwdata_in),
		.raw_in      (events),
		.prdata_out  (prdata_out),
		.pslverr_out (pslverr_out),
		.bus         (bus)
	);

	irq_mask_store u_store (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.event_in   (events),
		.bus        (bus)
	);

	// per-source gating toward the device interrupt; status still records masked alarms
	always_comb begin
		next_gated                  = bus.status & bus.mask;
		next_gated[BIT_EXT_FRAME]   = bus.status[BIT_EXT_FRAME] & bus.mask[BIT_EXT_FRAME];
		next_gated[BIT_SEC_CHANGE]  = bus.status[BIT_SEC_CHANGE] & bus.mask[BIT_SEC_CHANGE];
		next_gated[BIT_PHASE_ALARM] = bus.status[BIT_PHASE_ALARM] & bus.mask[BIT_PHASE_ALARM];
		next_gated[BIT_SEC_LOST]    = bus.status[BIT_SEC_LOST] & bus.mask[BIT_SEC_LOST];
		next_gated[BIT_B_CODE_ERR]  = bus.status[BIT_B_CODE_ERR] & bus.mask[BIT_B_CODE_ERR];
		next_gated[BIT_B_SIG_LOSS]  = bus.status[BIT_B_SIG_LOSS] & bus.mask[BIT_B_SIG_LOSS];
		next_gated[BIT_A_CODE_ERR]  = bus.status[BIT_A_CODE_ERR] & bus.mask[BIT_A_CODE_ERR];
		next_gated[BIT_A_SIG_LOSS]  = bus.status[BIT_A_SIG_LOSS] & bus.mask[BIT_A_SIG_LOSS];
	end

	assign gated_alarm_out = next_gated;
	assign irq_out         = |next_gated;

	// relations checked below use the stored enable and status bytes
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence write_mask_s;
		psel_in && penable_in && pwrite_in && (paddr_in == MASK_HI_ADDR);
	endsequence

	// an enable write landing at the same edge may legally change the outcome, so it is left out
	sequence mask_steady_s;
		!(psel_in && penable_in && pwrite_in && (paddr_in == MASK_HI_ADDR));
	endsequence

	ext_frame_gate_a: assert property (!bus.mask[BIT_EXT_FRAME] |-> !gated_alarm_out[BIT_EXT_FRAME])
		else $error("external frame alarm passed while masked");
	sec_lost_gate_a: assert property (bus.status[BIT_SEC_LOST] && bus.mask[BIT_SEC_LOST] |-> irq_out)
		else $error("secondary loss enabled but no irq");
	b_code_gate_a: assert property (gated_alarm_out[BIT_B_CODE_ERR] |-> bus.mask[BIT_B_CODE_ERR])
		else $error("coded b error passed while masked");
	b_loss_gate_a: assert property (($rose(coded_input_b_signal_loss_in) && bus.mask[BIT_B_SIG_LOSS])
		##0 mask_steady_s |=> irq_out)
		else $error("coded b loss did not raise irq");
	a_code_gate_a: assert property ((events[BIT_A_CODE_ERR] && bus.mask[BIT_A_CODE_ERR])
		##0 mask_steady_s |=> gated_alarm_out[BIT_A_CODE_ERR])
		else $error("coded a error gating wrong");
	a_loss_gate_a: assert property ((coded_input_a_signal_loss_in && !bus.mask[BIT_A_SIG_LOSS])
		##0 mask_steady_s |=> !gated_alarm_out[BIT_A_SIG_LOSS])
		else $error("coded a loss passed while masked");
	mask_write_a: assert property (write_mask_s |=> bus.mask == $past(pwdata_in[7:0]))
		else $error("enable byte not written");
	mask_hold_a: assert property (!(psel_in && penable_in && pwrite_in) |=> $stable(bus.mask))
		else $error("enable byte changed without write");
	sec_change_gate_a: assert property (!bus.mask[BIT_SEC_CHANGE] && !bus.mask[BIT_PHASE_ALARM]
		|-> !gated_alarm_out[BIT_SEC_CHANGE] && !gated_alarm_out[BIT_PHASE_ALARM])
		else $error("secondary change or phase alarm passed while masked");
	status_sticky_a: assert property (events[BIT_EXT_FRAME] |=> bus.status[BIT_EXT_FRAME])
		else $error("event did not set status");
	ext_frame_pass_a: assert property ((events[BIT_EXT_FRAME] && bus.mask[BIT_EXT_FRAME])
		##0 mask_steady_s |=> gated_alarm_out[BIT_EXT_FRAME])
		else $error("enabled external frame alarm did not pass");
	sec_change_pass_a: assert property ((events[BIT_SEC_CHANGE] && bus.mask[BIT_SEC_CHANGE])
		##0 mask_steady_s |=> gated_alarm_out[BIT_SEC_CHANGE])
		else $error("enabled secondary change did not pass");
	phase_alarm_pass_a: assert property ((events[BIT_PHASE_ALARM] && bus.mask[BIT_PHASE_ALARM])
		##0 mask_steady_s |=> gated_alarm_out[BIT_PHASE_ALARM])
		else $error("enabled phase alarm did not pass");
	sec_lost_pass_a: assert property ((events[BIT_SEC_LOST] && bus.mask[BIT_SEC_LOST])
		##0 mask_steady_s |=> gated_alarm_out[BIT_SEC_LOST])
		else $error("enabled secondary loss did not pass");
	b_code_pass_a: assert property ((events[BIT_B_CODE_ERR] && bus.mask[BIT_B_CODE_ERR])
		##0 mask_steady_s |=> gated_alarm_out[BIT_B_CODE_ERR])
		else $error("enabled coded b error did not pass");
	a_loss_pass_a: assert property ((events[BIT_A_SIG_LOSS] && bus.mask[BIT_A_SIG_LOSS])
		##0 mask_steady_s |=> gated_alarm_out[BIT_A_SIG_LOSS])
		else $error("enabled coded a loss did not pass");
endmodule

// File: interrupt_mask_upper_byte_tb.sv
// Purpose: self-checking bench for the upper interrupt enable byte over apb
// Assumes: zero wait state slave, status w1c at STATUS_ADDR, events sampled on rising edge
// Notes:   random masks and events from an lfsr seeded with 99, so every run is the same
module interrupt_mask_upper_byte_tb
	import irq_mask_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys_in;
	logic        rst_n_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [7:0]  ev;
	logic [7:0]  gated;
	logic [7:0]  lfsr;
	logic [7:0]  m;
	logic [7:0]  e;
	logic [7:0]  b;
	logic [31:0] rd;
	logic        er;
	int          err_count;
	int          n_tests;

	interrupt_mask_upper_byte interrupt_mask_upper_byte_inst (
		.clk_sys_in                     (clk_sys_in),
		.rst_n_in                       (rst_n_in),
		.psel_in                        (psel),
		.penable_in                     (penable),
		.pwrite_in                      (pwrite),
		.paddr_in                       (paddr),
		.pwdata_in                      (pwdata),
		.prdata_out                     (prdata),
		.pready_out                     (pready),
		.pslverr_out                    (pslverr),
		.ext_frame_pulse_alarm_in       (ev[7]),
		.secondary_path_state_change_in (ev[6]),
		.phase_monitor_alarm_in         (ev[5]),
		.secondary_path_sources_lost_in (ev[4]),
		.coded_input_b_code_error_in    (ev[3]),
		.coded_input_b_signal_loss_in   (ev[2]),
		.coded_input_a_code_error_in    (ev[1]),
		.coded_input_a_signal_loss_in   (ev[0]),
		.gated_alarm_out                (gated),
		.irq_out                        (irq)
	);

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask

	// request held from setup until pready is seen high; a wait that reaches 20 polled edges is flagged as an error
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic x);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
		r = prdata;
		x = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// one-cycle alarm pulse, then let the status update land before looking
	task automatic pulse(input logic [7:0] v);
		@(posedge clk_sys_in);
		ev <= v;
		@(posedge clk_sys_in);
		ev <= 8'h00;
		#1;
	endtask

	initial begin
		#(5000 * 100);
		err_count++;
		report_and_stop();
	end

	initial begin
		rst_n_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; ev = 8'h00;
		lfsr = 8'h63; err_count = 0; n_tests = 0;
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		apb(1'b0, MASK_HI_ADDR, 32'h0, rd, er);
		chk(rd, {24'h0, MASK_HI_RESET});
		pulse(8'hFF);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, STATUS_ADDR, 32'hFF, rd, er);
		for (int i = 0; i < SRC_COUNT; i++) begin
			b = 8'h01 << i;
			// all other sources enabled so a leak from the wrong bit shows up
			apb(1'b1, MASK_HI_ADDR, {24'h0, ~b}, rd, er);
			pulse(b);
			chk({31'h0, irq}, 32'h0);
			apb(1'b1, MASK_HI_ADDR, {24'h0, b}, rd, er);
			#1;
			chk({31'h0, irq}, 32'h1);
			chk({24'h0, gated}, {24'h0, b});
			apb(1'b1, STATUS_ADDR, {24'h0, b}, rd, er);
			#1;
			chk({31'h0, irq}, 32'h0);
		end
		apb(1'b1, 12'h200, 32'hFF, rd, er);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, MASK_HI_ADDR, 32'h0, rd, er);
		chk(rd, 32'h80);
		// live alarms read back raw; a clear in the same cycle as an alarm must lose
		ev <= 8'h81;
		apb(1'b0, RAW_ADDR, 32'h0, rd, er);
		chk(rd, 32'h81);
		apb(1'b1, STATUS_ADDR, 32'hFF, rd, er);
		ev <= 8'h00;
		apb(1'b0, STATUS_ADDR, 32'h0, rd, er);
		chk(rd, 32'h81);
		repeat (24) begin
			lfsr = lfsr_next(lfsr);
			m = lfsr;
			lfsr = lfsr_next(lfsr);
			e = lfsr;
			apb(1'b1, MASK_HI_ADDR, {24'hABCDEF, m}, rd, er);
			apb(1'b0, MASK_HI_ADDR, 32'h0, rd, er);
			chk(rd, {24'h0, m});
			chk({31'h0, er}, 32'h0);
			apb(1'b1, STATUS_ADDR, 32'hFF, rd, er);
			pulse(e);
			chk({24'h0, gated}, {24'h0, e & m});
			chk({31'h0, irq}, {31'h0, |(e & m)});
			// status records every alarm, masked or not
			apb(1'b0, STATUS_ADDR, 32'h0, rd, er);
			chk(rd, {24'h0, e});
		end
		// reset in mid-run must bring a nonzero enable byte back to all masked
		apb(1'b1, MASK_HI_ADDR, 32'hFF, rd, er);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		#1;
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, MASK_HI_ADDR, 32'h0, rd, er);
		chk(rd, {24'h0, MASK_HI_RESET});
		report_and_stop();
	end
endmodule
